// ===== logic/pxb_defs.vh
// Register offsets, field positions, reset values and routing codes.
`ifndef PXB_DEFS_VH
`define PXB_DEFS_VH

// Special function register offsets.
`define PXB_ADDR_SKIP      8'he1
`define PXB_ADDR_ROUTE     8'he2
`define PXB_ADDR_CTRL      8'he3
`define PXB_ADDR_PORT      8'hd0
`define PXB_ADDR_INMODE    8'hd1
`define PXB_ADDR_OUTMODE   8'hd2

// Reset values.
`define PXB_RST_SKIP       8'h00
`define PXB_RST_ROUTE      8'h00
`define PXB_RST_CTRL       8'h00
`define PXB_RST_PORT       8'hff
`define PXB_RST_INMODE     8'hff
`define PXB_RST_OUTMODE    8'h00

// Writable bits of the registers with unused bits.
`define PXB_MASK_SKIP      8'h7f
`define PXB_MASK_CTRL      8'hc7

// Routing register fields.
`define PXB_ROUTE_TX       0
`define PXB_ROUTE_RX       1
`define PXB_ROUTE_SMB      2
`define PXB_ROUTE_SYSCLK   3
`define PXB_ROUTE_CMP      4
`define PXB_ROUTE_CMPA     5
`define PXB_ROUTE_PCA_LO   6
`define PXB_ROUTE_PCA_HI   7

// Control register fields.
`define PXB_CTRL_ECI       0
`define PXB_CTRL_T0        1
`define PXB_CTRL_T1        2
`define PXB_CTRL_XBAR      6
`define PXB_CTRL_WEAK_PULLUP_DISABLE   7

// Pin selection codes, in decoder priority order; zero is plain port.
`define PXB_SEL_GPIO       4'h0
`define PXB_SEL_TX         4'h1
`define PXB_SEL_RX         4'h2
`define PXB_SEL_SDA        4'h3
`define PXB_SEL_SCL        4'h4
`define PXB_SEL_CMP        4'h5
`define PXB_SEL_CMPA       4'h6
`define PXB_SEL_SYSCLK     4'h7
`define PXB_SEL_PCA_MODULE_OUTPUT_ZERO       4'h8
`define PXB_SEL_CEX1       4'h9
`define PXB_SEL_CEX2       4'ha
`define PXB_SEL_ECI        4'hb
`define PXB_SEL_T0         4'hc
`define PXB_SEL_T1         4'hd

// Fixed serial pins.
`define PXB_TX_PIN         4
`define PXB_RX_PIN         5

`endif

// ===== logic/pxb_port_crossbar.v
// Port crossbar with general purpose port latch and its registers.
//
// Behaviour
// - Skip bit 0 leaves pin for decoder
// - Lowest free unskipped pin per non-serial signal
// - Crossbar disabled means plain port pins
// - Pull-ups on open-drain, off when low
// - Input mode 1 digital, 0 analog
// - Unassigned pins serve as port pins
// - Port register byte and bit access
// - Written latch keeps driving the pin
// - Plain read returns live pin levels
// - Read-modify-write reads latch contents
`include "pxb_defs.vh"

module pxb_port_crossbar #(
  parameter PINS = 8
) (
  // Clock and reset.
  input  wire            clk,
  input  wire            nrst,
  // Special function register access.
  input  wire [7:0]      sfrAddr,
  input  wire            sfrWrite,
  input  wire [7:0]      sfrWdata,
  input  wire            sfrRead,
  input  wire            sfrRmw,
  input  wire            bitWrite,
  input  wire [2:0]      bitIndex,
  input  wire            bitValue,
  output reg  [7:0]      sfrRdata,
  // Peripheral outputs toward the pins.
  input  wire            uartTx,
  input  wire            smbSdaOut,
  input  wire            smbSclOut,
  input  wire            cmpSync,
  input  wire            cmpAsync,
  input  wire            sysclkOut,
  input  wire [2:0]      pcaCex,
  // Pin levels toward the peripherals.
  output reg             uartRx,
  output reg             smbSdaIn,
  output reg             smbSclIn,
  output reg             pcaEci,
  output reg             timer0In,
  output reg             timer1In,
  // Package pins.
  input  wire [PINS-1:0] pinIn,
  output reg  [PINS-1:0] pinOut,
  output reg  [PINS-1:0] pinOe,
  output reg  [PINS-1:0] pullupEn,
  output reg  [PINS-1:0] digitalInEn
);

  //////////////////////////////////////////////////////////////////////////
  // Registers and decoder.

  reg  [7:0]        skipReg;
  reg  [7:0]        routeReg;
  reg  [7:0]        ctrlReg;
  reg  [PINS-1:0]   portLatch;
  reg  [PINS-1:0]   inMode;
  reg  [PINS-1:0]   outMode;
  wire [13:1]       sigEnable;
  wire [4*PINS-1:0] rawSel;
  wire [4*PINS-1:0] pinSel;
  wire [1:0]        pcaField;
  wire              xbarOn;
  wire [PINS-1:0]   liveLevel;

  assign pcaField = routeReg[`PXB_ROUTE_PCA_HI:`PXB_ROUTE_PCA_LO];
  assign xbarOn   = ctrlReg[`PXB_CTRL_XBAR];
  // Analog pins have their receiver off, so they read as low.
  assign liveLevel = pinIn & inMode;

  assign sigEnable[1]  = routeReg[`PXB_ROUTE_TX];
  assign sigEnable[2]  = routeReg[`PXB_ROUTE_RX];
  assign sigEnable[3]  = routeReg[`PXB_ROUTE_SMB];
  assign sigEnable[4]  = routeReg[`PXB_ROUTE_SMB];
  assign sigEnable[5]  = routeReg[`PXB_ROUTE_CMP];
  assign sigEnable[6]  = routeReg[`PXB_ROUTE_CMPA];
  assign sigEnable[7]  = routeReg[`PXB_ROUTE_SYSCLK];
  assign sigEnable[8]  = (pcaField != 2'b00);
  assign sigEnable[9]  = pcaField[1];
  assign sigEnable[10] = (pcaField == 2'b11);
  assign sigEnable[11] = ctrlReg[`PXB_CTRL_ECI];
  assign sigEnable[12] = ctrlReg[`PXB_CTRL_T0];
  assign sigEnable[13] = ctrlReg[`PXB_CTRL_T1];

  pxb_priority_decoder #(
    .PINS      (PINS)
  ) u_decoder (
    .skipBits  (skipReg[PINS-2:0]),
    .sigEnable (sigEnable),
    .pinSel    (rawSel)
  );

  assign pinSel = xbarOn ? rawSel : {4*PINS{1'b0}};

  // Level of the pin that carries a code, or a default when none does.
  function sigLevel;
    input [4*PINS-1:0] sel;
    input [PINS-1:0]   lvl;
    input [3:0]        code;
    input              dflt;
    integer            i;
    begin
      sigLevel = dflt;
      for (i = 0; i < PINS; i = i + 1) begin
        if (sel[4*i +: 4] == code) begin
          sigLevel = lvl[i];
        end
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register writes. Unused bits are never stored, so they read as zero.

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      skipReg   <= `PXB_RST_SKIP;
      routeReg  <= `PXB_RST_ROUTE;
      ctrlReg   <= `PXB_RST_CTRL;
      portLatch <= `PXB_RST_PORT;
      inMode    <= `PXB_RST_INMODE;
      outMode   <= `PXB_RST_OUTMODE;
    end else if (sfrWrite) begin
      case (sfrAddr)
        `PXB_ADDR_SKIP:    skipReg   <= sfrWdata & `PXB_MASK_SKIP;
        `PXB_ADDR_ROUTE:   routeReg  <= sfrWdata;
        `PXB_ADDR_CTRL:    ctrlReg   <= sfrWdata & `PXB_MASK_CTRL;
        `PXB_ADDR_PORT:    portLatch <= sfrWdata;
        `PXB_ADDR_INMODE:  inMode    <= sfrWdata;
        `PXB_ADDR_OUTMODE: outMode   <= sfrWdata;
        default:           skipReg   <= skipReg;
      endcase
    end else if (bitWrite) begin
      portLatch[bitIndex] <= bitValue;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register reads, answered on the edge after the request.

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfrRdata <= 8'h00;
    end else if (sfrRead) begin
      case (sfrAddr)
        `PXB_ADDR_SKIP:    sfrRdata <= skipReg;
        `PXB_ADDR_ROUTE:   sfrRdata <= routeReg;
        `PXB_ADDR_CTRL:    sfrRdata <= ctrlReg;
        `PXB_ADDR_PORT:    sfrRdata <= sfrRmw ? portLatch : liveLevel;
        `PXB_ADDR_INMODE:  sfrRdata <= inMode;
        `PXB_ADDR_OUTMODE: sfrRdata <= outMode;
        default:           sfrRdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drivers. Everything is registered, so pins follow one cycle late.

  reg [PINS-1:0] next_pinOut;
  reg [PINS-1:0] next_pinOe;
  reg [PINS-1:0] next_pullupEn;
  reg            drvVal;
  reg            openDrain;
  reg            inputOnly;
  reg [3:0]      code;
  integer        n;

  always @* begin
    next_pinOut   = {PINS{1'b0}};
    next_pinOe    = {PINS{1'b0}};
    next_pullupEn = {PINS{1'b0}};
    drvVal        = 1'b1;
    openDrain     = 1'b0;
    inputOnly     = 1'b0;
    code          = 4'h0;
    for (n = 0; n < PINS; n = n + 1) begin
      code      = pinSel[4*n +: 4];
      inputOnly = 1'b0;
      openDrain = ~outMode[n];
      case (code)
        `PXB_SEL_GPIO:   drvVal = portLatch[n];
        `PXB_SEL_TX:     drvVal = uartTx;
        `PXB_SEL_SDA:    drvVal = smbSdaOut;
        `PXB_SEL_SCL:    drvVal = smbSclOut;
        `PXB_SEL_CMP:    drvVal = cmpSync;
        `PXB_SEL_CMPA:   drvVal = cmpAsync;
        `PXB_SEL_SYSCLK: drvVal = sysclkOut;
        `PXB_SEL_PCA_MODULE_OUTPUT_ZERO:   drvVal = pcaCex[0];
        `PXB_SEL_CEX1:   drvVal = pcaCex[1];
        `PXB_SEL_CEX2:   drvVal = pcaCex[2];
        default: begin
          drvVal    = 1'b1;
          inputOnly = 1'b1;
        end
      endcase
      // Two-wire bus pins are open-drain whatever the output mode says.
      if (code == `PXB_SEL_SDA || code == `PXB_SEL_SCL) begin
        openDrain = 1'b1;
      end
      if (!inMode[n] || inputOnly) begin
        next_pinOe[n] = 1'b0;
      end else if (openDrain) begin
        next_pinOe[n] = ~drvVal;
      end else begin
        next_pinOut[n] = drvVal;
        next_pinOe[n]  = 1'b1;
      end
      next_pullupEn[n] = ~ctrlReg[`PXB_CTRL_WEAK_PULLUP_DISABLE] & inMode[n] &
                         openDrain & ~(next_pinOe[n] & ~drvVal);
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinOut      <= {PINS{1'b0}};
      pinOe       <= {PINS{1'b0}};
      pullupEn    <= {PINS{1'b0}};
      digitalInEn <= {PINS{1'b1}};
    end else begin
      pinOut      <= next_pinOut;
      pinOe       <= next_pinOe;
      pullupEn    <= next_pullupEn;
      digitalInEn <= inMode;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin levels back to the peripherals; idle level when no pin is given.

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uartRx   <= 1'b1;
      smbSdaIn <= 1'b1;
      smbSclIn <= 1'b1;
      pcaEci   <= 1'b0;
      timer0In <= 1'b0;
      timer1In <= 1'b0;
    end else begin
      uartRx   <= sigLevel(pinSel, liveLevel, `PXB_SEL_RX, 1'b1);
      smbSdaIn <= sigLevel(pinSel, liveLevel, `PXB_SEL_SDA, 1'b1);
      smbSclIn <= sigLevel(pinSel, liveLevel, `PXB_SEL_SCL, 1'b1);
      pcaEci   <= sigLevel(pinSel, liveLevel, `PXB_SEL_ECI, 1'b0);
      timer0In <= sigLevel(pinSel, liveLevel, `PXB_SEL_T0, 1'b0);
      timer1In <= sigLevel(pinSel, liveLevel, `PXB_SEL_T1, 1'b0);
    end
  end

endmodule // pxb_port_crossbar

// ===== logic/pxb_priority_decoder.v
// Priority crossbar decoder: maps enabled signals to pin selection codes.
`include "pxb_defs.vh"

module pxb_priority_decoder #(
  parameter PINS = 8
) (
  // Configuration.
  input  wire [PINS-2:0]   skipBits,
  input  wire [13:1]       sigEnable,
  // Result, four bits per pin.
  output reg  [4*PINS-1:0] pinSel
);

  reg [PINS-1:0] taken;
  reg            found;
  integer        k;
  integer        p;

  // Serial pins are fixed; all others take the lowest free pin in order.
  always @* begin
    pinSel = {4*PINS{1'b0}};
    taken  = {1'b0, skipBits};
    if (sigEnable[1]) begin
      pinSel[4*`PXB_TX_PIN +: 4] = `PXB_SEL_TX;
    end
    if (sigEnable[2]) begin
      pinSel[4*`PXB_RX_PIN +: 4] = `PXB_SEL_RX;
    end
    taken[`PXB_TX_PIN] = taken[`PXB_TX_PIN] | sigEnable[1];
    taken[`PXB_RX_PIN] = taken[`PXB_RX_PIN] | sigEnable[2];
    for (k = 3; k <= 13; k = k + 1) begin
      found = 1'b0;
      for (p = 0; p < PINS; p = p + 1) begin
        if (sigEnable[k] && !found && !taken[p]) begin
          found       = 1'b1;
          taken[p]    = 1'b1;
          pinSel[4*p +: 4] = k[3:0];
        end
      end
    end
  end

endmodule // pxb_priority_decoder

// ===== sim/pxb_pin_model.sv
// Pad model: external drivers, weak pull-ups and floating lines.
module pxb_pin_model (
  // Clock.
  input  logic       clk,
  // Pad control from the block.
  input  logic [7:0] pinOut,
  input  logic [7:0] pinOe,
  input  logic [7:0] pullupEn,
  // External forcing from the bench.
  input  logic [7:0] extEn,
  input  logic [7:0] extVal,
  // Resolved pad levels.
  output logic [7:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lastLvl = 8'h00;
  // A released pad without pull-up flips each cycle, never a stale level.
  always @(posedge clk)
    lastLvl <= pinIn;
  // External driver wins, then the block, then the pull-up.
  assign pinIn = extEn & extVal
               | ~extEn & (pinOe & pinOut | ~pinOe & (pullupEn | ~lastLvl));
endmodule // pxb_pin_model

// ===== sim/pxb_port_crossbar_chk.sv
// Port-level assertions for the port crossbar block.
module pxb_port_crossbar_chk #(
  parameter PINS = 8
) (
  // Clock, reset and register bus.
  input logic            clk,
  input logic            nrst,
  input logic [7:0]      sfrAddr,
  input logic            sfrWrite,
  input logic [7:0]      sfrWdata,
  input logic            sfrRead,
  input logic            sfrRmw,
  input logic [7:0]      sfrRdata,
  // Peripheral side.
  input logic            uartTx,
  input logic            uartRx,
  input logic            pcaEci,
  // Package pins.
  input logic [PINS-1:0] pinIn,
  input logic [PINS-1:0] pinOut,
  input logic [PINS-1:0] pinOe,
  input logic [PINS-1:0] pullupEn,
  input logic [PINS-1:0] digitalInEn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] route;
  logic [7:0] ctrl;
  logic [7:0] inMode;
  // Pad level as seen outside; undriven counts as released high.
  wire        lvl4 = pinOe[4] ? pinOut[4] : 1'b1;
  wire        mapped = sfrAddr inside {8'hd0, 8'hd1, 8'hd2,
                                       8'he1, 8'he2, 8'he3};
  ////////////////////////////////////////////////////////////////////
  // Shadow copies load on the same edge as the block's own registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      route  <= 8'h00;
      ctrl   <= 8'h00;
      inMode <= 8'hff;
    end else if (sfrWrite) begin
      if (sfrAddr == 8'he2)
        route <= sfrWdata;
      if (sfrAddr == 8'he3)
        ctrl <= sfrWdata;
      if (sfrAddr == 8'hd1)
        inMode <= sfrWdata;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // A read request at a given address.
  sequence s_rd(a);
    sfrRead && sfrAddr == a;
  endsequence
  property p_unmapped;
    sfrRead && !mapped |=> sfrRdata == 8'h00;
  endproperty
  property p_hold;
    !sfrRead |=> $stable(sfrRdata);
  endproperty
  property p_skipTop;
    s_rd(8'he1) |=> !sfrRdata[7];
  endproperty
  property p_ctrlGap;
    s_rd(8'he3) |=> sfrRdata[5:3] == 3'h0;
  endproperty
  property p_portRead;
    s_rd(8'hd0) ##0 !sfrRmw |=> sfrRdata == $past(pinIn & inMode);
  endproperty
  property p_pullLow;
    (pullupEn & pinOe & ~pinOut) == '0;
  endproperty
  property p_analog;
    (~digitalInEn & (pinOe | pullupEn)) == '0;
  endproperty
  property p_xbarOff;
    !ctrl[6] |=> uartRx && !pcaEci;
  endproperty
  property p_txPin;
    ctrl[6] && route[0] && inMode[4] |=> lvl4 == $past(uartTx);
  endproperty
  property p_rxPin;
    ctrl[6] && route[1] |=> uartRx == $past(pinIn[5] & inMode[5]);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_skipTop: assert property (p_skipTop) else $error("skip bit7 set");
  a_ctrlGap: assert property (p_ctrlGap) else $error("ctrl gap set");
  a_portRead: assert property (p_portRead) else $error("port read");
  a_pullLow: assert property (p_pullLow) else $error("pull on low");
  a_analog: assert property (p_analog) else $error("analog driven");
  a_xbarOff: assert property (p_xbarOff) else $error("xbar off");
  a_txPin: assert property (p_txPin) else $error("tx pin");
  a_rxPin: assert property (p_rxPin) else $error("rx pin");
endmodule // pxb_port_crossbar_chk

bind pxb_port_crossbar pxb_port_crossbar_chk #(.PINS(PINS)) u_chk (
  .clk, .nrst, .sfrAddr, .sfrWrite, .sfrWdata, .sfrRead, .sfrRmw,
  .sfrRdata, .uartTx, .uartRx, .pcaEci, .pinIn, .pinOut, .pinOe,
  .pullupEn, .digitalInEn);

// ===== sim/pxb_port_crossbar_tb.sv
// Self-checking testbench for the port crossbar.
module pxb_port_crossbar_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, nrst = 0, sfrWrite = 0, sfrRead = 0, sfrRmw = 0;
  logic       bitWrite = 0, bitValue = 0, uartTx = 1, smbSdaOut = 1;
  logic       smbSclOut = 1, cmpSync = 1, cmpAsync = 1, sysclkOut = 1;
  logic [2:0] bitIndex = 3'h0, pcaCex = 3'h7;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00;
  logic [7:0] extEn = 8'h00, extVal = 8'h00;
  logic       uartRx, smbSdaIn, smbSclIn, pcaEci, timer0In, timer1In;
  logic [7:0] sfrRdata, pinIn, pinOut, pinOe, pullupEn, digitalInEn;
  int         n_mismatch = 0, checks_done = 0, cycles = 0;
  // Clock at 125 MHz.
  always #4 clk = ~clk;
  pxb_port_crossbar #(.PINS(8)) DUT (.clk, .nrst, .sfrAddr, .sfrWrite,
    .sfrWdata, .sfrRead, .sfrRmw, .bitWrite, .bitIndex, .bitValue,
    .sfrRdata, .uartTx, .smbSdaOut, .smbSclOut, .cmpSync, .cmpAsync,
    .sysclkOut, .pcaCex, .uartRx, .smbSdaIn, .smbSclIn, .pcaEci,
    .timer0In, .timer1In, .pinIn, .pinOut, .pinOe, .pullupEn,
    .digitalInEn);
  pxb_pin_model u_pins (.clk, .pinOut, .pinOe, .pullupEn, .extEn,
    .extVal, .pinIn);
  ////////////////////////////////////////////////////////////////////
  task automatic ck(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write, then leave two edges so pins settle.
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(posedge clk);
    sfrAddr <= a;
    sfrRmw <= m;
    sfrRead <= 1'b1;
    @(posedge clk);
    sfrRead <= 1'b0;
    #1 ck(sfrRdata, e);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] a [7] = '{8'he1, 8'he2, 8'he3, 8'hd0, 8'hd1, 8'hd2, 8'he0};
    logic [7:0] r [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
    logic [7:0] m [4] = '{8'h7f, 8'hff, 8'hc7, 8'h00};
    for (int i = 0; i < 7; i++)
      rd(a[i], 1'b0, r[i]);
    for (int i = 0; i < 4; i++) begin
      wr(a[i == 3 ? 6 : i], 8'hff);
      rd(a[i == 3 ? 6 : i], 1'b0, m[i]);
      wr(a[i == 3 ? 6 : i], 8'h00);
    end
    $display("t_regs done");
  endtask
  task automatic t_gpio;
    wr(8'hd2, 8'hff);
    wr(8'hd0, 8'h5a);
    rd(8'hd0, 1'b0, 8'h5a);
    @(posedge clk);
    bitValue <= 1'b1;
    bitWrite <= 1'b1;
    @(posedge clk);
    bitWrite <= 1'b0;
    rd(8'hd0, 1'b0, 8'h5b);
    wr(8'hd2, 8'h00);
    wr(8'hd0, 8'hff);
    extEn <= 8'h08;
    rd(8'hd0, 1'b0, 8'hf7);
    rd(8'hd0, 1'b1, 8'hff);
    @(posedge clk);
    extEn <= 8'h00;
    $display("t_gpio done");
  endtask
  task automatic t_skip;
    @(posedge clk);
    cmpSync <= 1'b0;
    smbSdaOut <= 1'b0;
    wr(8'he1, 8'h01);
    wr(8'he2, 8'h14);
    wr(8'he3, 8'h01);
    #1 ck(pinIn, 8'hff);
    wr(8'he3, 8'h41);
    #1 ck(pinIn, 8'hf5);
    ck({6'h00, pcaEci, smbSdaIn}, 8'h02);
    wr(8'he3, 8'h40);
    #1 ck({7'h00, pcaEci}, 8'h00);
    // Timer inputs take pins 4 and 5; pin 5 is pulled low from outside.
    @(posedge clk);
    extEn <= 8'h20;
    wr(8'he3, 8'h46);
    #1 ck({4'h0, timer0In, timer1In, smbSdaIn, smbSclIn}, 8'h09);
    @(posedge clk);
    extEn <= 8'h00;
    $display("t_skip done");
  endtask
  task automatic t_pca;
    @(posedge clk);
    uartTx <= 1'b0;
    pcaCex <= 3'h0;
    cmpAsync <= 1'b0;
    sysclkOut <= 1'b0;
    wr(8'he1, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(8'he2, {f[1:0], 6'h03});
      #1 ck(pinIn, ~(((8'h01 << f) - 8'h01) | 8'h10));
    end
    @(posedge clk);
    extEn <= 8'h20;
    repeat (2) @(posedge clk);
    #1 ck({7'h00, uartRx}, 8'h00);
    @(posedge clk);
    extEn <= 8'h00;
    uartTx <= 1'b1;
    // Asynchronous comparator and clock output take pins 0 and 1, low.
    wr(8'he2, 8'h28);
    #1 ck(pinIn, 8'hfc);
    $display("t_pca done");
  endtask
  task automatic t_mode;
    wr(8'he3, 8'h00);
    wr(8'hd1, 8'hfe);
    rd(8'hd0, 1'b0, 8'hfe);
    ck(digitalInEn, 8'hfe);
    wr(8'hd0, 8'hef);
    #1 ck(pullupEn, 8'hee);
    wr(8'he3, 8'h80);
    #1 ck(pullupEn, 8'h00);
    $display("t_mode done");
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard well above the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs;
    t_gpio;
    t_skip;
    t_pca;
    t_mode;
    end_of_test;
  end
endmodule // pxb_port_crossbar_tb
